/* motor_cmd_pkg.sv */
// Constants for the serial motor command slave
package motor_cmd_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD = 19200;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned SILENCE_S = 2;
  localparam int unsigned SILENCE_CYCLES = SILENCE_S * CLK_HZ;
  localparam logic [7:0] START_CHAR = 8'h23;
  localparam logic [7:0] PACKET_TERMINATOR = 8'h0D;
  localparam logic [7:0] STATUS_INQUIRY_COMMAND = 8'h24;
  localparam logic [7:0] ADDR_QUERY_CMD = 8'h4D;
  localparam logic [7:0] STORE_READ_CMD = 8'h5A;
  localparam logic [7:0] BROADCAST_ADDR = 8'hFF;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF9;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam int unsigned RX_DEPTH = 8;
  localparam int unsigned TX_DEPTH = 8;
endpackage

/* motor_cmd_slave.sv */
// Command interpreter for the addressed serial motor protocol
// Operation
// - Packet is start char, address, command, then command data.
// - Packet ends with one terminator byte.
// - Characters are 8N1 framed.
// - Link runs at fixed 19200 baud.
// - Own address 1..249 selects this unit.
// - Address 255 selects every unit.
// - Only complete valid packets execute; faulty ones are dropped.
// - Each byte of a packet for this unit up to the eighth body byte, except start char and terminator, is echoed.
// - No echo for broadcast packets, except the command byte leading an address query answer.
// - Read answers append data after the echoed index digits, then terminator.
// - Gap over two seconds drops partial packet.
// - Status query answers address, command, status, terminator.
// - Status bits 0..3 ready, zero reached, error, profile end.
// - Bits 4..7 one-hot mode; clock-direction forces ready.
// - Address query answers address as three ASCII digits.
// - Stored-data read echoes address, command and index digits, then answers three ASCII data digits.
// - Unit transmits only in answer to a request.
`timescale 1ns/1ps
`default_nettype none
module motor_cmd_slave
  import motor_cmd_pkg::*;
#(
  parameter int unsigned SILENCE_CYC = SILENCE_CYCLES,
  parameter int unsigned BIT_CYC = BIT_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Serial line
  input wire logic rxd_i,
  output logic txd_o,
  output logic tx_en_o,
  // Configuration
  input wire logic [7:0] unit_addr_i,
  // Status sources
  input wire logic ready_i,
  input wire logic zero_reached_i,
  input wire logic pos_error_i,
  input wire logic profile_end_i,
  input wire logic [3:0] mode_onehot_i,
  // Stored data port
  output logic [7:0] store_addr_o,
  input wire logic [7:0] store_data_i,
  // Events
  output logic packet_done_o,
  output logic packet_drop_o
);
  typedef enum logic [3:0] {
    R_IDLE = 4'b0001,
    R_ADDR = 4'b0010,
    R_BODY = 4'b0100,
    R_SKIP = 4'b1000
  } rx_state_e;

  logic rst_sync1_q, rst_n;
  logic rxd_s1_q, rxd_q;
  rx_state_e state_q;
  logic [15:0] rcnt_q;
  logic [3:0] rbit_q;
  logic [7:0] rshift_q;
  logic rx_busy_q, rx_stb_q;
  logic [7:0] rx_byte_q;
  logic [31:0] gap_q;
  logic bcast_q;
  logic [2:0] nbody_q;
  logic [7:0] body_q [RX_DEPTH];
  logic [7:0] txbuf_q [TX_DEPTH];
  logic [3:0] twr_q, trd_q;
  logic tx_ready, tx_busy;
  logic [7:0] store_idx;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_sync1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_sync1_q <= 1'b1;
      rst_n <= rst_sync1_q;
    end
  end

  function automatic logic [7:0] digit(input logic [7:0] v, input int p);
    logic [7:0] d;
    d = (p == 2) ? v / 8'd100 : (p == 1) ? (v / 8'd10) % 8'd10 : v % 8'd10;
    return d + ASCII_ZERO;
  endfunction

  function automatic logic [7:0] ascii_val(input logic [7:0] c);
    return c - ASCII_ZERO;
  endfunction

  // Line sync; rxd_s1_q read only by rxd_q
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxd_s1_q <= 1'b1;
      rxd_q <= 1'b1;
    end
    else
    begin
      rxd_s1_q <= rxd_i;
      rxd_q <= rxd_s1_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_busy_q <= 1'b0;
      rcnt_q <= 16'h0000;
      rbit_q <= 4'h0;
      rshift_q <= 8'h00;
      rx_stb_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end
    else
    begin
      rx_stb_q <= 1'b0;
      if (!rx_busy_q)
      begin
        if (!rxd_q)
        begin
          rx_busy_q <= 1'b1;
          rcnt_q <= 16'(BIT_CYC / 2);
          rbit_q <= 4'h0;
        end
      end
      else if (rcnt_q == 16'(BIT_CYC - 1))
      begin
        rcnt_q <= 16'h0000;
        rbit_q <= rbit_q + 4'h1;
        if (rbit_q == 4'h0 && rxd_q)
          rx_busy_q <= 1'b0;
        else if (rbit_q >= 4'h1 && rbit_q <= 4'h8)
          rshift_q <= {rxd_q, rshift_q[7:1]};
        else if (rbit_q == 4'h9)
        begin
          // Bad stop bit drops the character
          rx_busy_q <= 1'b0;
          rx_stb_q <= rxd_q;
          rx_byte_q <= rshift_q;
        end
      end
      else
        rcnt_q <= rcnt_q + 16'h0001;
    end
  end

  logic addr_own, addr_bc, do_exec;
  logic [2:0] need;
  assign addr_own = rx_byte_q == unit_addr_i && unit_addr_i >= ADDR_MIN
                    && unit_addr_i <= ADDR_MAX;
  assign addr_bc = rx_byte_q == BROADCAST_ADDR;
  assign need = (body_q[0] == STORE_READ_CMD) ? 3'd4 : 3'd1;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= R_IDLE;
      bcast_q <= 1'b0;
      nbody_q <= 3'd0;
      gap_q <= 32'h0000_0000;
      packet_drop_o <= 1'b0;
    end
    else
    begin
      packet_drop_o <= 1'b0;
      if (rx_stb_q || state_q == R_IDLE)
        gap_q <= 32'h0000_0000;
      else
        gap_q <= gap_q + 32'h0000_0001;
      if (state_q != R_IDLE && !rx_stb_q
          && gap_q >= 32'(SILENCE_CYC))
      begin
        state_q <= R_IDLE;
        packet_drop_o <= 1'b1;
      end
      else if (rx_stb_q)
      begin
        case (state_q)
          R_IDLE:
            if (rx_byte_q == START_CHAR)
              state_q <= R_ADDR;
          R_ADDR:
          begin
            bcast_q <= addr_bc;
            nbody_q <= 3'd0;
            state_q <= (addr_own || addr_bc) ? R_BODY : R_SKIP;
          end
          R_BODY:
            if (rx_byte_q == PACKET_TERMINATOR)
              state_q <= R_IDLE;
            else if (nbody_q == 3'(RX_DEPTH - 1))
            begin
              state_q <= R_SKIP;
              packet_drop_o <= 1'b1;
            end
            else
              nbody_q <= nbody_q + 3'd1;
          R_SKIP:
            if (rx_byte_q == PACKET_TERMINATOR)
              state_q <= R_IDLE;
          default:
            state_q <= R_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < RX_DEPTH; i++)
        body_q[i] <= 8'h00;
    else if (rx_stb_q && state_q == R_BODY)
      body_q[nbody_q] <= rx_byte_q;
  end

  // execute only a complete, well-sized packet
  assign do_exec = rx_stb_q && state_q == R_BODY
                   && rx_byte_q == PACKET_TERMINATOR && nbody_q == need
                   && (body_q[0] == STATUS_INQUIRY_COMMAND
                       || body_q[0] == ADDR_QUERY_CMD
                       || body_q[0] == STORE_READ_CMD);
  assign store_idx = 8'(ascii_val(body_q[1]) * 8'd100
                     + ascii_val(body_q[2]) * 8'd10 + ascii_val(body_q[3]));
  assign tx_en_o = tx_busy || (trd_q != twr_q);

  logic [7:0] status_b;
  assign status_b = {mode_onehot_i, profile_end_i, pos_error_i,
                     zero_reached_i, ready_i | mode_onehot_i[3]};

  // answer queue fed only by host packets
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      twr_q <= 4'h0;
      trd_q <= 4'h0;
      packet_done_o <= 1'b0;
      store_addr_o <= 8'h00;
      for (int i = 0; i < TX_DEPTH; i++)
        txbuf_q[i] <= 8'h00;
    end
    else
    begin
      packet_done_o <= do_exec;
      if (tx_ready && trd_q != twr_q)
        trd_q <= trd_q + 4'h1;
      store_addr_o <= store_idx;
      // echo bytes; not on broadcast
      // Own address byte echoed too; broadcast and foreign stay silent
      if (rx_stb_q && twr_q - trd_q < 4'h7
          && ((state_q == R_ADDR && addr_own && !addr_bc)
              || (state_q == R_BODY && !bcast_q && !do_exec
                  && rx_byte_q != PACKET_TERMINATOR)))
      begin
        txbuf_q[twr_q[2:0]] <= rx_byte_q;
        twr_q <= twr_q + 4'h1;
      end
      else if (do_exec && !bcast_q && body_q[0] == STATUS_INQUIRY_COMMAND)
      begin
        txbuf_q[twr_q[2:0]] <= status_b;
        txbuf_q[3'(twr_q[2:0] + 3'd1)] <= PACKET_TERMINATOR;
        twr_q <= twr_q + 4'h2;
      end
      else if (do_exec && body_q[0] == ADDR_QUERY_CMD)
      begin
        // address as three digits, command echo included
        txbuf_q[twr_q[2:0]] <= body_q[0];
        txbuf_q[3'(twr_q[2:0] + 3'd1)] <= digit(unit_addr_i, 2);
        txbuf_q[3'(twr_q[2:0] + 3'd2)] <= digit(unit_addr_i, 1);
        txbuf_q[3'(twr_q[2:0] + 3'd3)] <= digit(unit_addr_i, 0);
        txbuf_q[3'(twr_q[2:0] + 3'd4)] <= PACKET_TERMINATOR;
        twr_q <= twr_q + 4'h5;
      end
      else if (do_exec && !bcast_q && body_q[0] == STORE_READ_CMD)
      begin
        txbuf_q[twr_q[2:0]] <= digit(store_data_i, 2);
        txbuf_q[3'(twr_q[2:0] + 3'd1)] <= digit(store_data_i, 1);
        txbuf_q[3'(twr_q[2:0] + 3'd2)] <= digit(store_data_i, 0);
        txbuf_q[3'(twr_q[2:0] + 3'd3)] <= PACKET_TERMINATOR;
        twr_q <= twr_q + 4'h4;
      end
    end
  end

  uart_tx_byte #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .valid_i(trd_q != twr_q),
    .data_i(txbuf_q[trd_q[2:0]]),
    .ready_o(tx_ready),
    .txd_o(txd_o),
    .busy_o(tx_busy)
  );

  chk_foreign_no_exec: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    state_q == R_SKIP |-> !do_exec) else $error("skip packet executed");
  chk_bcast_no_echo: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    rx_stb_q && bcast_q && state_q == R_BODY && body_q[0] != ADDR_QUERY_CMD
    |=> twr_q == $past(twr_q)) else $error("broadcast echoed");
  chk_gap_drop: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    state_q != R_IDLE && !rx_stb_q && gap_q >= 32'(SILENCE_CYC)
    |=> state_q == R_IDLE) else $error("gap not dropped");
  chk_quiet_tx: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    !tx_en_o |-> txd_o) else $error("line driven while idle");
  chk_idle_stray: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    state_q == R_IDLE && rx_stb_q && rx_byte_q != START_CHAR
    |=> state_q == R_IDLE) else $error("stray byte accepted");
  chk_echo_queued: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    rx_stb_q && !bcast_q && state_q == R_BODY && !do_exec
    && rx_byte_q != PACKET_TERMINATOR && twr_q - trd_q < 4'h7
    |=> twr_q == $past(twr_q) + 4'h1) else $error("echo missing");
  chk_addr_echo: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    rx_stb_q && state_q == R_ADDR && addr_own && twr_q == trd_q
    |=> twr_q == $past(twr_q) + 4'h1) else $error("address not echoed");
  chk_done_pulse: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    do_exec |=> packet_done_o ##1 !packet_done_o) else $error("done wrong");
  chk_term_idle: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    rx_stb_q && state_q == R_BODY && rx_byte_q == PACKET_TERMINATOR
    |=> state_q == R_IDLE) else $error("terminator missed");
  cov_exec: cover property (@(posedge clk_i) do_exec);
  cov_drop: cover property (@(posedge clk_i) packet_drop_o);
  cov_skip: cover property (@(posedge clk_i) state_q == R_SKIP);
endmodule
`default_nettype wire

/* motor_host_model.sv */
// Host model for the shared serial pair
`timescale 1ns/1ps
`default_nettype none
module motor_host_model
#(
  parameter int unsigned BIT_CYC = 16
)
(
  // Clock
  input wire logic clk_i,
  // Serial pair
  output logic rxd_o,
  input wire logic txd_i,
  input wire logic tx_en_i,
  // Byte heard from the unit
  output logic [7:0] byte_o,
  output logic byte_stb_o
);
  logic line;
  logic [7:0] shift;
  // Bias resistors pull the released bus high
  assign line = tx_en_i ? txd_i : 1'b1;
  initial
  begin
    rxd_o = 1'b1;
    byte_o = 8'h00;
    byte_stb_o = 1'b0;
  end
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk_i);
      rxd_o = frame[i];
      repeat (BIT_CYC - 1) @(negedge clk_i);
    end
  endtask
  always
  begin
    @(negedge line);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk_i);
      shift[i] = line;
    end
    repeat (BIT_CYC) @(posedge clk_i);
    byte_o <= shift;
    byte_stb_o <= 1'b1;
    @(posedge clk_i);
    byte_stb_o <= 1'b0;
  end
endmodule
`default_nettype wire

/* serial_motor_command_slave_bench.sv */
// Self-checking bench for the motor command slave
`timescale 1ns/1ps
`default_nettype none
`define CMP(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("unexpected %s: expected %h, seen %h", what, exp, got); \
    end \
  end
module serial_motor_command_slave_bench;
  import motor_cmd_pkg::*;
  localparam int unsigned BC = 16;
  localparam int unsigned SC = 2000;
  logic clk = 1'b0;
  logic rstn, rxd, txd, tx_en, ready, zero, err, prof, done, drop, stb;
  logic [7:0] unit_addr, store_addr, store_data, heard, exp_b, sa;
  logic [3:0] mode;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int checked = 0;
  int dones = 0;
  int drops = 0;
  always #5 clk = ~clk;
  // Arbitrary stored contents
  assign store_data = store_addr ^ 8'h5c;
  motor_cmd_slave #(.SILENCE_CYC(SC), .BIT_CYC(BC)) i_dut (
    .clk_i(clk), .rstn_i(rstn), .rxd_i(rxd), .txd_o(txd), .tx_en_o(tx_en),
    .unit_addr_i(unit_addr), .ready_i(ready), .zero_reached_i(zero),
    .pos_error_i(err), .profile_end_i(prof), .mode_onehot_i(mode),
    .store_addr_o(store_addr), .store_data_i(store_data),
    .packet_done_o(done), .packet_drop_o(drop));
  motor_host_model #(.BIT_CYC(BC)) i_host (
    .clk_i(clk), .rxd_o(rxd), .txd_i(txd), .tx_en_i(tx_en),
    .byte_o(heard), .byte_stb_o(stb));
  function automatic logic [23:0] dec3(input logic [7:0] v);
    return {ASCII_ZERO + v / 8'd100, ASCII_ZERO + (v / 8'd10) % 8'd10,
      ASCII_ZERO + v % 8'd10};
  endfunction
  task automatic note3(input logic [23:0] v);
    exp_q.push_back(v[23:16]);
    exp_q.push_back(v[15:8]);
    exp_q.push_back(v[7:0]);
  endtask
  task automatic packet(input logic [7:0] a, input logic [7:0] c,
    input logic [23:0] d, input int n);
    i_host.send_byte(START_CHAR);
    i_host.send_byte(a);
    i_host.send_byte(c);
    for (int i = 0; i < n; i++)
      i_host.send_byte(d[23 - 8 * i -: 8]);
    i_host.send_byte(PACKET_TERMINATOR);
  endtask
  task automatic conclude();
    $display("Counts: %0d mismatches in %0d checks", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for a silent line, then all notes must be used
  task automatic quiet();
    int idle;
    idle = 0;
    for (int n = 0; n < 20000 && idle < 40 * BC; n++)
    begin
      @(negedge clk);
      idle = (tx_en === 1'b0) ? idle + 1 : 0;
    end
    if (idle < 40 * BC)
    begin
      mismatches++;
      $display("unexpected hang: expected idle line, seen busy");
      conclude();
    end
    `CMP("leftover notes", 0, exp_q.size())
  endtask
  // Oldest note against each byte heard; spare bytes are faults
  always @(posedge clk)
    if (stb === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        mismatches++;
        $display("unexpected byte: expected none, seen %h", heard);
      end
      else
      begin
        exp_b = exp_q.pop_front();
        `CMP("tx byte", exp_b, heard)
      end
    end
  always @(posedge clk)
  begin
    dones += (done === 1'b1);
    drops += (drop === 1'b1);
  end
  initial
  begin
    rstn = 1'b0;
    unit_addr = 8'h01;
    {ready, zero, err, prof} = 4'h0;
    mode = 4'h1;
    void'($urandom(32'h09cd_5587));
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    i_host.send_byte(8'h41);
    i_host.send_byte(PACKET_TERMINATOR);
    quiet();
    for (int k = 0; k < 6; k++)
    begin
      @(negedge clk);
      unit_addr = (k == 0) ? ADDR_MIN : (k == 1) ? ADDR_MAX :
        8'(1 + $urandom % 249);
      {ready, zero, err, prof} = 4'($urandom);
      mode = 4'h1 << (k % 4);
      exp_q.push_back(unit_addr);
      exp_q.push_back(STATUS_INQUIRY_COMMAND);
      exp_q.push_back({mode, prof, err, zero, ready | mode[3]});
      exp_q.push_back(PACKET_TERMINATOR);
      packet(unit_addr, STATUS_INQUIRY_COMMAND, 24'h0, 0);
      quiet();
    end
    packet(unit_addr ^ 8'h02, STATUS_INQUIRY_COMMAND, 24'h0, 0);
    quiet();
    for (int k = 0; k < 3; k++)
    begin
      @(negedge clk);
      ready = 1'b1;
      unit_addr = (k == 0) ? ADDR_MIN : (k == 1) ? ADDR_MAX :
        8'(1 + $urandom % 249);
      exp_q.push_back(ADDR_QUERY_CMD);
      note3(dec3(unit_addr));
      exp_q.push_back(PACKET_TERMINATOR);
      packet(BROADCAST_ADDR, ADDR_QUERY_CMD, 24'h0, 0);
      quiet();
    end
    exp_q.push_back(unit_addr);
    exp_q.push_back(STATUS_INQUIRY_COMMAND);
    i_host.send_byte(START_CHAR);
    i_host.send_byte(unit_addr);
    i_host.send_byte(STATUS_INQUIRY_COMMAND);
    repeat (SC + 400) @(negedge clk);
    i_host.send_byte(PACKET_TERMINATOR);
    quiet();
    // overlong packet dropped after its echo
    exp_q.push_back(unit_addr);
    repeat (RX_DEPTH) exp_q.push_back(8'h41);
    i_host.send_byte(START_CHAR);
    i_host.send_byte(unit_addr);
    repeat (RX_DEPTH + 1) i_host.send_byte(8'h41);
    i_host.send_byte(PACKET_TERMINATOR);
    quiet();
    `CMP("drop pulses", 2, drops)
    // stored data read after the drop
    // only reads are sent, so no storing wait
    for (int k = 0; k < 2; k++)
    begin
      sa = (k == 0) ? 8'd10 : 8'($urandom);
      exp_q.push_back(unit_addr);
      exp_q.push_back(STORE_READ_CMD);
      note3(dec3(sa));
      note3(dec3(sa ^ 8'h5c));
      exp_q.push_back(PACKET_TERMINATOR);
      packet(unit_addr, STORE_READ_CMD, dec3(sa), 3);
      quiet();
    end
    `CMP("done pulses", 11, dones)
    conclude();
  end
endmodule
`default_nettype wire

/* uart_tx_byte.sv */
// Serial byte transmitter, 8N1
`timescale 1ns/1ps
`default_nettype none
module uart_tx_byte
  import motor_cmd_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Byte in
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  output logic ready_o,
  // Line
  output logic txd_o,
  output logic busy_o
);
  logic [9:0] shift_q;
  logic [3:0] bits_q;
  logic [15:0] cnt_q;

  assign ready_o = (bits_q == 4'h0);
  assign busy_o = !ready_o;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      shift_q <= 10'h3FF;
      bits_q <= 4'h0;
      cnt_q <= 16'h0000;
      txd_o <= 1'b1;
    end
    else if (bits_q == 4'h0)
    begin
      txd_o <= 1'b1;
      if (valid_i)
      begin
        shift_q <= {1'b1, data_i, 1'b0};
        bits_q <= 4'hA;
        cnt_q <= 16'h0000;
      end
    end
    else
    begin
      txd_o <= shift_q[0];
      if (cnt_q == 16'(BIT_CYC - 1))
      begin
        cnt_q <= 16'h0000;
        shift_q <= {1'b1, shift_q[9:1]};
        bits_q <= bits_q - 4'h1;
      end
      else
      begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire
